/* shared/cwd_pkg.sv */
// Constants and state layout for the CPU watchdog timer.
// Assumes a 200 MHz system clock and a 16-bit host I/O address space.
`default_nettype none
package cwd_pkg;
  localparam logic [15:0] CWD_PORT_ADDR = 16'h0443;
  localparam logic [7:0] CWD_CODE_MIN = 8'h01;
  localparam logic [7:0] CWD_CODE_MAX = 8'h3E;
  localparam logic [7:0] CWD_RDATA_RST = 8'h00;
  localparam int unsigned CWD_CLK_PERIOD_NS = 5;
  localparam int unsigned CWD_SEC_NS = 1000000000;
  localparam int unsigned CWD_SEC_CYCLES_DEF = CWD_SEC_NS / CWD_CLK_PERIOD_NS;
  localparam int unsigned CWD_RST_PULSE_NS = 100;
  localparam logic [7:0] CWD_RST_PULSE_CYC = 8'((CWD_RST_PULSE_NS +
    CWD_CLK_PERIOD_NS - 1) / CWD_CLK_PERIOD_NS);

  typedef struct packed {
    logic active;
    logic [7:0] secs;
    logic [31:0] presc;
    logic [7:0] pulse;
    logic [7:0] rdata;
    logic cpu_rst;
  } cwd_state_s;

  localparam cwd_state_s CWD_STATE_RST = '{
    active: 1'b0, secs: 8'h00, presc: 32'h00000000, pulse: 8'h00,
    rdata: CWD_RDATA_RST, cpu_rst: 1'b0};
endpackage : cwd_pkg
`default_nettype wire

/* verilog/cwd_top.sv */
// CPU watchdog timer reached through one host I/O port.
// Assumes io_* strobes are single-cycle and synchronous to clk.
//
// Contract
// - Expired countdown pulses the CPU reset.
// - Port write enables and loads timeout byte.
// - Codes 01 to 3E give 1-62 seconds.
// - Each rewrite restarts countdown from new value.
// - Port read disables the watchdog.
`default_nettype none
module cwd_top
  import cwd_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = CWD_SEC_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic wd_active,
  output logic cpu_rst
);
  cwd_state_s st;
  cwd_state_s next_st;
  logic hit_wr;
  logic hit_rd;
  logic code_ok;
  logic wr_ok;
  logic tick;
  logic expire;

  assign hit_wr = io_wr && (io_addr == CWD_PORT_ADDR);
  assign hit_rd = io_rd && (io_addr == CWD_PORT_ADDR);
  // Out-of-range codes are dropped so a stray byte cannot arm a 0 s timer
  assign code_ok = (io_wdata >= CWD_CODE_MIN) &&
    (io_wdata <= CWD_CODE_MAX);
  assign wr_ok = hit_wr && code_ok;
  assign tick = st.presc == 32'(SEC_CYCLES - 1);
  assign expire = st.active && tick && (st.secs == 8'h01);

  always_comb begin
    next_st = st;
    if (st.pulse != 8'h00) begin
      next_st.pulse = st.pulse - 8'h01;
    end
    if (st.active) begin
      if (tick) begin
        next_st.presc = 32'h00000000;
        next_st.secs = st.secs - 8'h01;
      end else begin
        next_st.presc = st.presc + 32'h00000001;
      end
    end
    if (expire) begin
      next_st.active = 1'b0;
      next_st.pulse = CWD_RST_PULSE_CYC;
    end
    if (hit_rd) begin
      next_st.rdata = st.secs;
      next_st.active = 1'b0;
    end
    // A write in the same cycle as expiry or a read wins: software is alive
    if (wr_ok) begin
      next_st.active = 1'b1;
      next_st.secs = io_wdata;
      next_st.presc = 32'h00000000;
      if (expire) begin
        next_st.pulse = st.pulse - ((st.pulse != 8'h00) ? 8'h01 : 8'h00);
      end
    end
    next_st.cpu_rst = next_st.pulse != 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= CWD_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata = st.rdata;
  assign wd_active = st.active;
  assign cpu_rst = st.cpu_rst;

  sequence s_expire;
    expire && !wr_ok;
  endsequence

  sequence s_pulse;
    cpu_rst [*8];
  endsequence

  // Idle is checked on the first pulse cycle only: a write may re-arm later
  property p_expiry;
    @(posedge clk) disable iff (!rst_n)
      s_expire |=> !wd_active ##0 s_pulse;
  endproperty

  chk_expiry_reset: assert property (p_expiry)
    else $error("expiry did not pulse cpu reset");

  sequence s_pulse_start;
    cpu_rst && (st.pulse == CWD_RST_PULSE_CYC);
  endsequence

  property p_pulse_load;
    @(posedge clk) disable iff (!rst_n)
      s_expire |=> s_pulse_start;
  endproperty

  chk_pulse_load: assert property (p_pulse_load)
    else $error("reset pulse not loaded at expiry");

  sequence s_pulse_run;
    (st.pulse != 8'h00) && !(expire && !wr_ok);
  endsequence

  property p_pulse_count;
    @(posedge clk) disable iff (!rst_n)
      s_pulse_run |=> st.pulse == $past(st.pulse) - 8'h01;
  endproperty

  chk_pulse_count: assert property (p_pulse_count)
    else $error("reset pulse counter did not step down");

  chk_pulse_end: assert property (@(posedge clk)
    disable iff (!rst_n)
    $fell(cpu_rst) |-> $past(st.pulse) == 8'h01)
    else $error("cpu reset pulse ended early");

  chk_write_load: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr_ok |=> wd_active && (st.secs == $past(io_wdata)))
    else $error("valid write did not arm watchdog");

  chk_write_wins: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr_ok && hit_rd |=> wd_active && (io_rdata == $past(st.secs)))
    else $error("write and read together did not arm");

  chk_other_addr: assert property (@(posedge clk)
    disable iff (!rst_n)
    (io_wr || io_rd) && (io_addr != CWD_PORT_ADDR) && !expire
    |=> wd_active == $past(wd_active))
    else $error("access to another port changed state");

  chk_bad_code: assert property (@(posedge clk)
    disable iff (!rst_n)
    hit_wr && !code_ok && !hit_rd && !tick && !expire
    |=> (st.secs == $past(st.secs)) && (wd_active == $past(wd_active)))
    else $error("invalid code changed state");

  sequence s_sec_tick;
    st.active && tick && !expire && !wr_ok;
  endsequence

  property p_sec_step;
    @(posedge clk) disable iff (!rst_n)
      s_sec_tick |=> (st.secs == $past(st.secs) - 8'h01) &&
      (st.presc == 32'h00000000);
  endproperty

  chk_sec_step: assert property (p_sec_step)
    else $error("second tick did not count down");

  sequence s_presc_run;
    st.active && !tick && !wr_ok;
  endsequence

  property p_presc_step;
    @(posedge clk) disable iff (!rst_n)
      s_presc_run |=> st.presc == $past(st.presc) + 32'h00000001;
  endproperty

  chk_presc_step: assert property (p_presc_step)
    else $error("prescaler did not advance");

  // A second write straight after the first restarts the count again
  chk_restart_count: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr_ok |=> (st.presc == 32'h00000000) ##1
    (!wd_active || $past(wr_ok) || (st.presc == 32'h00000001)))
    else $error("rewrite did not restart countdown");

  chk_late_write: assert property (@(posedge clk)
    disable iff (!rst_n)
    expire && wr_ok && !cpu_rst |=> wd_active && !cpu_rst)
    else $error("write in expiry cycle still reset the cpu");

  chk_read_off: assert property (@(posedge clk)
    disable iff (!rst_n)
    hit_rd && !wr_ok |=> !wd_active && (io_rdata == $past(st.secs)))
    else $error("read did not disable watchdog");

  chk_rdata_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    !hit_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");

  chk_active_drop: assert property (@(posedge clk)
    disable iff (!rst_n)
    $fell(wd_active) |-> $past(hit_rd || expire))
    else $error("watchdog stopped without read or expiry");

  chk_idle_quiet: assert property (@(posedge clk)
    disable iff (!rst_n)
    !wd_active && !cpu_rst |=> !cpu_rst)
    else $error("cpu reset while watchdog idle");

  chk_idle_frozen: assert property (@(posedge clk)
    disable iff (!rst_n)
    !wd_active && !wr_ok
    |=> (st.secs == $past(st.secs)) && (st.presc == $past(st.presc)))
    else $error("idle watchdog kept counting");

  chk_arm_by_write: assert property (@(posedge clk)
    disable iff (!rst_n)
    $rose(wd_active) |-> $past(wr_ok))
    else $error("watchdog armed without a write");

  chk_reset_idle: assert property (@(posedge clk)
    !rst_n |=> !wd_active && !cpu_rst)
    else $error("watchdog not idle after reset");
endmodule : cwd_top
`default_nettype wire

/* sim/cwd_cpu.sv */
// CPU reset input model: counts reset pulses and their width.
// Assumes cpu_rst is synchronous to clk.
`default_nettype none
module cwd_cpu (
  input wire logic clk,
  input wire logic cpu_rst,
  output var int pulses,
  output var int width
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  initial begin
    pulses = 0;
    width = 0;
    run = 0;
    forever begin
      // Falling edge keeps the sample clear of the edge that launches it
      @(negedge clk);
      // Width is only known on the fall, so a cut pulse still counts
      if (cpu_rst) run++;
      else if (run > 0) begin
        width = run;
        pulses++;
        run = 0;
      end
    end
  end
endmodule // cwd_cpu
`default_nettype wire

/* sim/test_cwd_top.sv */
// Bench for the CPU watchdog: port write table, then timing cases.
// Assumes a 10-cycle second and the cwd_cpu reset model.
`default_nettype none
module test_cwd_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cwd_pkg::*;
  logic clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, wd_active, cpu_rst;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, io_rdata;
  int failures = 0, compares = 0, pulses, width;
  logic [24:0] rows [5] = '{{16'h0443, 8'h01, 1'b1},
    {16'h0443, 8'h3E, 1'b1}, {16'h0443, 8'h00, 1'b0},
    {16'h0443, 8'h3F, 1'b0}, {16'h0043, 8'h05, 1'b0}};
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  always #2.5 clk = ~clk;
  cwd_top #(.SEC_CYCLES(10)) dut_u (.clk(clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .wd_active(wd_active), .cpu_rst(cpu_rst));
  cwd_cpu cpu_u (.clk(clk), .cpu_rst(cpu_rst), .pulses(pulses),
    .width(width));
  task automatic op(logic [15:0] a, logic w, logic r, logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wr = w;
    io_rd = r;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("idle", 10'h000, {wd_active, cpu_rst, io_rdata})
    foreach (rows[i]) begin
      op(rows[i][24:9], 1'b1, 1'b0, rows[i][8:1]);
      `CHK("row_on", rows[i][0], wd_active)
      op(16'h0443, 1'b0, 1'b1, 8'h00);
      `CHK("row_off", 1'b0, wd_active)
    end
    op(16'h0443, 1'b1, 1'b0, 8'h02);
    repeat (19) @(negedge clk);
    `CHK("early", 1'b0, cpu_rst)
    @(negedge clk);
    `CHK("expire", 2'b10, {cpu_rst, wd_active})
    repeat (21) @(negedge clk);
    `CHK("pulse", CWD_RST_PULSE_CYC, width)
    `CHK("after", 2'b00, {cpu_rst, wd_active})
    op(16'h0443, 1'b1, 1'b0, 8'h02);
    repeat (14) @(negedge clk);
    op(16'h0443, 1'b1, 1'b0, 8'h01);
    repeat (9) @(negedge clk);
    `CHK("restart", 1'b0, cpu_rst)
    @(negedge clk);
    `CHK("reload", 1'b1, cpu_rst)
    repeat (22) @(negedge clk);
    op(16'h0443, 1'b1, 1'b0, 8'h01);
    repeat (4) @(negedge clk);
    op(16'h0443, 1'b0, 1'b1, 8'h00);
    `CHK("remain", 8'h01, io_rdata)
    repeat (20) @(negedge clk);
    `CHK("quiet", 2, pulses)
    op(16'h0443, 1'b1, 1'b1, 8'h03);
    `CHK("both_on", 1'b1, wd_active)
    `CHK("both_rd", 8'h01, io_rdata)
    op(16'h0443, 1'b1, 1'b0, 8'h01);
    repeat (8) @(negedge clk);
    op(16'h0443, 1'b1, 1'b0, 8'h01);
    `CHK("late_wr", 2'b01, {cpu_rst, wd_active})
    repeat (10) @(negedge clk);
    `CHK("cut_on", 1'b1, cpu_rst)
    repeat (5) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("in_rst", 10'h000, {wd_active, cpu_rst, io_rdata})
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("rst_idle", 10'h000, {wd_active, cpu_rst, io_rdata})
    `CHK("cut", 3, pulses)
    op(16'h0443, 1'b1, 1'b0, 8'h3E);
    `CHK("rearm", 1'b1, wd_active)
    wrap_up();
  end
  initial begin
    #5000;
    failures++;
    wrap_up();
  end
endmodule // test_cwd_top
`default_nettype wire
